// *** pmwc_top.sv ***
// Power-mode and wake-up controller: FAST/SLOW run modes, SLEEP and three
// IDLE modes, status flags, watchdog clear and wake-up sequencing.
// Assumes stop and clear-instruction requests are one-cycle pulses from the
// core on clk; oscillator ready and port pins are asynchronous levels.
`timescale 1ns/10ps
`include "pmwc_defs.svh"

module pmwc_top #(
  parameter int SLOW_DIV = `PMWC_SLOW_DIV
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] clock_select_field,
  input wire logic hs_osc_idle_enable,
  input wire logic ls_osc_idle_enable,
  input wire logic hs_osc_control,
  input wire logic stop_instr,
  input wire logic watchdog_clear_instruction,
  input wire logic wdt_enable,
  input wire logic wdt_overflow,
  input wire logic hs_osc_ready,
  input wire logic ls_osc_ready,
  input wire logic [`PMWC_PORT_W-1:0] port_pins,
  input wire logic [`PMWC_PORT_W-1:0] port_wake_enable,
  input wire logic [`PMWC_IRQ_W-1:0] irq_request,
  input wire logic [`PMWC_IRQ_W-1:0] irq_enable,
  input wire logic stack_full,
  output logic sys_clk_en,
  output logic fast_clk_run,
  output logic slow_clk_run,
  output logic slow_mode_active,
  output logic cpu_halt,
  output logic hold_state,
  output logic hs_osc_stable_flag,
  output logic power_down_flag,
  output logic watchdog_timeout_flag,
  output logic wdt_counter_clear,
  output logic wdt_count_run,
  output logic wake_resume,
  output logic wake_irq_service,
  output logic wake_pc_sp_reset
);

  // ---------------------------------------------------------------------
  // Oscillator ready synchronisers
  // ---------------------------------------------------------------------
  logic [1:0] rdy_s1;
  logic [1:0] rdy_s2;
  logic [1:0] rdy_s3;
  logic [1:0] rdy_lvl;
  wire [1:0] rdy_agree;

  assign rdy_agree = ~(rdy_s2 ^ rdy_s3);

  // Three stages, a level counts once stages two and three agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdy_s1 <= 2'h0;
      rdy_s2 <= 2'h0;
      rdy_s3 <= 2'h0;
      rdy_lvl <= 2'h0;
    end else begin
      rdy_s1 <= {ls_osc_ready, hs_osc_ready};
      rdy_s2 <= rdy_s1;
      rdy_s3 <= rdy_s2;
      rdy_lvl <= (rdy_agree & rdy_s3) | (~rdy_agree & rdy_lvl);
    end
  end

  wire hs_ready = rdy_lvl[0];
  wire ls_ready = rdy_lvl[1];

  // ---------------------------------------------------------------------
  // Pin wake-up detection
  // ---------------------------------------------------------------------
  pmwc_wake_if wk ();

  assign wk.enable = port_wake_enable;

  pmwc_pin_wake u_pin_wake (
    .clk(clk),
    .rst_n(rst_n),
    .port_pins(port_pins),
    .wk(wk)
  );

  // ---------------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------------
  pmwc_pkg::pmwc_state_t state;
  pmwc_pkg::pmwc_state_t next_state;
  logic sel_slow;
  logic [`PMWC_IRQ_W-1:0] irq_blocked;
  logic wake_by_irq;
  logic wake_by_wdt;
  logic [5:0] fast_div;
  logic [`PMWC_SLOW_CNT_W-1:0] slow_cnt;
  logic slow_tick;

  wire in_run = (state == pmwc_pkg::PMWC_RUN);
  wire in_wake = (state == pmwc_pkg::PMWC_WAKE);
  wire in_low = ~in_run & ~in_wake;

  // Stop instruction is taken only while running
  wire stop_take = in_run & stop_instr;

  // Interrupts already pending at entry are blocked from waking
  wire [`PMWC_IRQ_W-1:0] irq_wake_vec = irq_request & ~irq_blocked;
  wire irq_wake = |irq_wake_vec;
  wire irq_serviceable = |(irq_wake_vec & irq_enable) & ~stack_full;
  wire pin_wake = |wk.fall;

  // Any wake source ends SLEEP or IDLE
  wire wake_evt = in_low & (pin_wake | irq_wake | wdt_overflow);

  // Oscillator of the selected system clock is stable
  wire src_stable = sel_slow ? ls_ready : hs_osc_stable_flag;

  // Mode selected by the idle enable bits at the stop instruction
  wire [1:0] idle_sel = {hs_osc_idle_enable, ls_osc_idle_enable};

  // Next power state
  always_comb begin
    next_state = state;
    case (state)
      pmwc_pkg::PMWC_RUN: begin
        if (stop_instr) begin
          case (idle_sel)
            2'h0: next_state = pmwc_pkg::PMWC_SLEEP;
            2'h1: next_state = pmwc_pkg::PMWC_IDLE_SLOW;
            2'h3: next_state = pmwc_pkg::PMWC_IDLE_BOTH;
            default: next_state = pmwc_pkg::PMWC_IDLE_FAST;
          endcase
        end
      end
      pmwc_pkg::PMWC_SLEEP,
      pmwc_pkg::PMWC_IDLE_SLOW,
      pmwc_pkg::PMWC_IDLE_BOTH,
      pmwc_pkg::PMWC_IDLE_FAST: begin
        if (wake_evt) begin
          next_state = pmwc_pkg::PMWC_WAKE;
        end
      end
      pmwc_pkg::PMWC_WAKE: begin
        if (src_stable) begin
          next_state = pmwc_pkg::PMWC_RUN;
        end
      end
      default: next_state = pmwc_pkg::PMWC_RUN;
    endcase
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= pmwc_pkg::PMWC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // Blocked-interrupt snapshot taken at entry to low power
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_blocked <= '0;
    end else if (stop_take) begin
      irq_blocked <= irq_request;
    end
  end

  // Wake cause, kept until the next wake event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_by_irq <= 1'b0;
      wake_by_wdt <= 1'b0;
    end else if (wake_evt) begin
      wake_by_irq <= irq_serviceable & ~wdt_overflow;
      wake_by_wdt <= wdt_overflow;
    end
  end

  // ---------------------------------------------------------------------
  // Clock source selection and oscillator flags
  // ---------------------------------------------------------------------
  wire want_slow = (clock_select_field == `PMWC_CKS_SLOW);

  // Switch to slow only on a stable slow oscillator, back on a stable fast one
  wire next_sel_slow = (in_run & want_slow & ls_ready) ? 1'b1 :
                       (in_run & ~want_slow & hs_osc_stable_flag) ? 1'b0 :
                       sel_slow;

  // Fast oscillator runs in RUN and WAKE when enabled or the source, and in fast idles
  // Leaving slow selection restarts the fast oscillator so its flag can rise
  wire next_fast_run = in_run ? (hs_osc_control | ~want_slow | ~next_sel_slow) :
                       in_wake ? (hs_osc_control | ~sel_slow) :
                       (state == pmwc_pkg::PMWC_IDLE_BOTH) | (state == pmwc_pkg::PMWC_IDLE_FAST);

  // Slow clock is stopped in SLEEP and in fast-only idle
  wire next_slow_run = ~((state == pmwc_pkg::PMWC_SLEEP) | (state == pmwc_pkg::PMWC_IDLE_FAST));

  // Stable flag is cleared while off, set once a running oscillator is ready
  wire next_hs_flag = fast_clk_run & hs_ready;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sel_slow <= `PMWC_RST_SEL_SLOW;
      fast_clk_run <= 1'b1;
      slow_clk_run <= 1'b1;
      hs_osc_stable_flag <= 1'b0;
    end else begin
      sel_slow <= next_sel_slow;
      fast_clk_run <= next_fast_run;
      slow_clk_run <= next_slow_run;
      hs_osc_stable_flag <= next_hs_flag;
    end
  end

  // ---------------------------------------------------------------------
  // System clock enable dividers
  // ---------------------------------------------------------------------
  wire [5:0] div_mask = (clock_select_field == `PMWC_CKS_DIV1) ? `PMWC_MASK_DIV1 :
                        (clock_select_field == `PMWC_CKS_DIV2) ? `PMWC_MASK_DIV2 :
                        (clock_select_field == `PMWC_CKS_DIV4) ? `PMWC_MASK_DIV4 :
                        (clock_select_field == `PMWC_CKS_DIV8) ? `PMWC_MASK_DIV8 :
                        (clock_select_field == `PMWC_CKS_DIV16) ? `PMWC_MASK_DIV16 :
                        `PMWC_MASK_DIV64;
  wire fast_tick = ((fast_div & div_mask) == div_mask) & fast_clk_run;
  wire slow_wrap = (slow_cnt == SLOW_DIV[`PMWC_SLOW_CNT_W-1:0] - 16'h0001);

  // Free-running fast divider and slow clock emulation from the main clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fast_div <= 6'h00;
      slow_cnt <= '0;
      slow_tick <= 1'b0;
    end else begin
      fast_div <= fast_div + 6'h01;
      slow_cnt <= (slow_wrap | ~slow_clk_run) ? '0 : slow_cnt + 16'h0001;
      slow_tick <= slow_wrap & slow_clk_run;
    end
  end

  // System clock stops outside RUN, already in the cycle the halt takes effect
  wire next_sys_en = (next_state == pmwc_pkg::PMWC_RUN) &
                     (sel_slow ? slow_tick : (fast_tick & hs_osc_stable_flag));

  // ---------------------------------------------------------------------
  // Status flags and watchdog control
  // ---------------------------------------------------------------------
  wire wdt_wake = in_low & wdt_overflow;

  // Power-down flag: set on stop, cleared by the clear instruction, set wins
  wire next_pdf = stop_take ? 1'b1 :
                  watchdog_clear_instruction ? 1'b0 :
                  power_down_flag;

  // Timeout flag: cleared on entry, set by overflow; overflow wins
  wire next_to = wdt_overflow ? 1'b1 :
                 stop_take ? 1'b0 :
                 watchdog_timeout_flag;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_down_flag <= `PMWC_RST_PDF;
      watchdog_timeout_flag <= `PMWC_RST_TO;
    end else begin
      power_down_flag <= next_pdf;
      watchdog_timeout_flag <= next_to;
    end
  end

  // Watchdog clear on entry and on clear instruction; counts only if enabled
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wdt_counter_clear <= 1'b0;
      wdt_count_run <= 1'b0;
    end else begin
      wdt_counter_clear <= stop_take | watchdog_clear_instruction;
      wdt_count_run <= wdt_enable;
    end
  end

  // ---------------------------------------------------------------------
  // Core control outputs
  // ---------------------------------------------------------------------
  wire wake_done = in_wake & src_stable;
  wire next_halt = (next_state != pmwc_pkg::PMWC_RUN);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_clk_en <= 1'b0;
      slow_mode_active <= 1'b0;
      cpu_halt <= 1'b0;
      hold_state <= 1'b0;
      wake_resume <= 1'b0;
      wake_irq_service <= 1'b0;
      wake_pc_sp_reset <= 1'b0;
    end else begin
      sys_clk_en <= next_sys_en;
      slow_mode_active <= next_sel_slow;
      cpu_halt <= next_halt;
      hold_state <= next_halt;
      wake_resume <= wake_done & ~wake_by_irq & ~wake_by_wdt;
      wake_irq_service <= wake_done & wake_by_irq;
      wake_pc_sp_reset <= wdt_wake;
    end
  end

endmodule

// *** pmwc_defs.svh ***
// Constants of the power-mode and wake-up controller: clock select codes,
// widths, reset values and timing counts.
// Assumes a single 250 MHz clock and a slow oscillator near 32 kHz.
//
// Overview of operation
// - In SLOW mode the system clock comes from the slow clock.
// - A restarted fast oscillator must stabilise; readiness shows on hs_osc_stable_flag.
// - SLEEP is entered only by stop with both idle enables at 0.
// - SLEEP stops every clock except the watchdog; execution halts.
// - Stop with fast idle 0, slow idle 1 enters idle_slow_clock_only.
// - Stop with both idle enables at 1 enters idle_both_clocks.
// - Stop with fast idle 1, slow idle 0 enters idle_fast_clock_only.
// - Memory, registers and ports hold their state in SLEEP and IDLE.
// - Entering SLEEP or IDLE sets power_down_flag and clears watchdog_timeout_flag.
// - Entering SLEEP or IDLE clears the watchdog; it counts only if enabled.
// - Wake on enabled pin falling edge, system interrupt or watchdog overflow.
// - power_down_flag clears at power-up and on watchdog_clear_instruction.
// - Watchdog overflow in low power sets timeout flag, resets only PC and SP.
// - Each pin wakes only when its enable bit is set, on falling edge.
// - After a pin wake-up execution resumes after the stop instruction.
// - Disabled interrupt or full stack: resume after stop, interrupt stays pending.
// - Enabled interrupt with free stack level: normal interrupt response on wake.
// - An interrupt flag already set at entry cannot wake the device.
// - Select codes: 000 fast, 001 /2, 010 /4, 011 /8, 100 /16, 101 /64, 111 slow.
// - Enabling the fast oscillator clears its stable flag, then sets it when stable.
// - Switching to SLOW completes only once the slow oscillator is stable.
`ifndef PMWC_DEFS_SVH
`define PMWC_DEFS_SVH

// Clock select codes
`define PMWC_CKS_DIV1 3'h0
`define PMWC_CKS_DIV2 3'h1
`define PMWC_CKS_DIV4 3'h2
`define PMWC_CKS_DIV8 3'h3
`define PMWC_CKS_DIV16 3'h4
`define PMWC_CKS_DIV64 3'h5
`define PMWC_CKS_RSVD 3'h6
`define PMWC_CKS_SLOW 3'h7

// Divider masks: a tick fires when the masked counter bits are all ones
`define PMWC_MASK_DIV1 6'h00
`define PMWC_MASK_DIV2 6'h01
`define PMWC_MASK_DIV4 6'h03
`define PMWC_MASK_DIV8 6'h07
`define PMWC_MASK_DIV16 6'h0f
`define PMWC_MASK_DIV64 6'h3f

// Widths
`define PMWC_PORT_W 8
`define PMWC_IRQ_W 4
`define PMWC_SLOW_CNT_W 16

// Reset values
`define PMWC_RST_PDF 1'b0
`define PMWC_RST_TO 1'b0
`define PMWC_RST_SEL_SLOW 1'b0

// Timing: clock period and slow clock period in ns
`define PMWC_CLK_PERIOD_NS 4
`define PMWC_SLOW_PERIOD_NS 31250
`define PMWC_SLOW_DIV (`PMWC_SLOW_PERIOD_NS / `PMWC_CLK_PERIOD_NS)

`endif

// *** pmwc_pkg.sv ***
// Types of the power-mode and wake-up controller.
// Assumes nothing beyond a SystemVerilog compiler.
package pmwc_pkg;

  // Power state of the core
  typedef enum logic [2:0] {
    PMWC_RUN,
    PMWC_SLEEP,
    PMWC_IDLE_SLOW,
    PMWC_IDLE_BOTH,
    PMWC_IDLE_FAST,
    PMWC_WAKE
  } pmwc_state_t;

endpackage

// *** pmwc_wake_if.sv ***
// Interface carrying pin wake enables and detected falling edges.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps
`include "pmwc_defs.svh"

interface pmwc_wake_if;
  logic [`PMWC_PORT_W-1:0] enable;
  logic [`PMWC_PORT_W-1:0] fall;

  modport det (input enable, output fall);
  modport ctl (output enable, input fall);
endinterface

// *** pmwc_pin_wake.sv ***
// Pin falling-edge detector for wake-up, one lane per port pin.
// Assumes port pins are asynchronous to clk; clk runs in all power modes.
`timescale 1ns/10ps
`include "pmwc_defs.svh"

module pmwc_pin_wake (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [`PMWC_PORT_W-1:0] port_pins,
  pmwc_wake_if.det wk
);

  wire [`PMWC_PORT_W-1:0] fall_q;

  assign wk.fall = fall_q;

  genvar i;
  generate
    for (i = 0; i < `PMWC_PORT_W; i = i + 1) begin : g_lane
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
      logic fq;
      wire agree;
      wire fell;

      // Each lane owns one bit of the detected-fall word
      assign fall_q[i] = fq;

      // Stable level changes only once the second and third stage agree
      assign agree = (s2 == s3);
      assign fell = agree & lvl & ~s3;

      // Three-stage synchroniser and filtered level
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1 <= 1'b1;
          s2 <= 1'b1;
          s3 <= 1'b1;
          lvl <= 1'b1;
          fq <= 1'b0;
        end else begin
          s1 <= port_pins[i];
          s2 <= s1;
          s3 <= s2;
          if (agree) begin
            lvl <= s3;
          end
          fq <= fell & wk.enable[i];
        end
      end
    end
  endgenerate

endmodule

// *** pmwc_top_asserts.sv ***
// Checker of the power-mode controller: outputs tied to their causes.
// Assumes it is bound to pmwc_top; one clock, reset async active low.
`timescale 1ns/10ps
`include "pmwc_defs.svh"

module pmwc_top_asserts (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [2:0] clock_select_field,
  input wire logic hs_osc_idle_enable,
  input wire logic ls_osc_idle_enable,
  input wire logic stop_instr,
  input wire logic watchdog_clear_instruction,
  input wire logic wdt_enable,
  input wire logic wdt_overflow,
  input wire logic sys_clk_en,
  input wire logic fast_clk_run,
  input wire logic slow_clk_run,
  input wire logic slow_mode_active,
  input wire logic cpu_halt,
  input wire logic hold_state,
  input wire logic power_down_flag,
  input wire logic watchdog_timeout_flag,
  input wire logic wdt_counter_clear,
  input wire logic wdt_count_run,
  input wire logic wake_resume,
  input wire logic wake_irq_service,
  input wire logic wake_pc_sp_reset
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  // Stop accepted while running, then with a given pair of idle enables
  sequence stop_take;
    stop_instr && !cpu_halt && !wdt_overflow;
  endsequence
  sequence stop_mode(logic h, logic l);
    stop_take ##0 (hs_osc_idle_enable == h && ls_osc_idle_enable == l);
  endsequence

  // Entry effects and clock gating per mode
  stop_flags_a: assert property (stop_take |=>
    cpu_halt && power_down_flag && !watchdog_timeout_flag && wdt_counter_clear) else $error("stop entry wrong");
  sleep_clocks_a: assert property (stop_mode(1'b0, 1'b0) |=> ##1 !fast_clk_run && !slow_clk_run)
    else $error("sleep clocks wrong");
  idle_slow_a: assert property (stop_mode(1'b0, 1'b1) |=> ##1 !fast_clk_run && slow_clk_run)
    else $error("slow-only idle clocks wrong");
  idle_both_a: assert property (stop_mode(1'b1, 1'b1) |=> ##1 fast_clk_run && slow_clk_run)
    else $error("both-clock idle clocks wrong");
  idle_fast_a: assert property (stop_mode(1'b1, 1'b0) |=> ##1 fast_clk_run && !slow_clk_run)
    else $error("fast-only idle clocks wrong");
  halt_hold_a: assert property (hold_state == cpu_halt && !(cpu_halt && sys_clk_en))
    else $error("hold or tick while halted wrong");

  // Flags, watchdog and wake results
  clr_pdf_a: assert property (watchdog_clear_instruction && !stop_instr |=> !power_down_flag)
    else $error("clear instruction left power down flag");
  ovf_to_a: assert property (wdt_overflow |=> watchdog_timeout_flag)
    else $error("overflow did not set timeout flag");
  ovf_wake_a: assert property (wdt_overflow && cpu_halt |=> wake_pc_sp_reset && !wake_resume)
    else $error("overflow wake wrong");
  wake_exit_a: assert property (wake_resume || wake_irq_service |-> !cpu_halt && $past(cpu_halt))
    else $error("wake pulse without leaving halt");
  wdt_run_a: assert property ($past(rst_n) |-> wdt_count_run == $past(wdt_enable))
    else $error("watchdog run does not follow enable");
  slow_sel_a: assert property ($rose(slow_mode_active) |-> $past(clock_select_field) == `PMWC_CKS_SLOW)
    else $error("slow mode without slow select");
endmodule

bind pmwc_top pmwc_top_asserts u_chk (.*);

// *** pmwc_core_model.sv ***
// Core model: turns bench requests into stop and clear-instruction pulses.
// Assumes the controller shares clk; a halted core executes nothing.
`timescale 1ns/10ps

module pmwc_core_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cpu_halt,
  input wire logic req_stop,
  input wire logic req_clr,
  output logic stop_instr,
  output logic watchdog_clear_instruction
);
  // One-cycle instruction pulses, only while running
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_instr <= 1'b0;
      watchdog_clear_instruction <= 1'b0;
    end else begin
      stop_instr <= req_stop && !cpu_halt;
      watchdog_clear_instruction <= req_clr && !cpu_halt;
    end
  end
endmodule

// *** tb_power_mode_wake_controller.sv ***
// Bench of the power-mode controller: run modes, stop entry, wake sources.
// Assumes pmwc_top, the core model and the checker bind are compiled.
`timescale 1ns/10ps
`include "pmwc_defs.svh"

module tb_power_mode_wake_controller;
  localparam int SLOW = 8;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] clock_select_field = 3'h0;
  logic hs_osc_idle_enable = 1'b0;
  logic ls_osc_idle_enable = 1'b0;
  logic hs_osc_control = 1'b0;
  logic wdt_enable = 1'b1;
  logic wdt_overflow = 1'b0;
  logic hs_osc_ready = 1'b1;
  logic ls_osc_ready = 1'b1;
  logic [`PMWC_PORT_W-1:0] port_pins = 8'hff;
  logic [`PMWC_PORT_W-1:0] port_wake_enable = 8'h00;
  logic [`PMWC_IRQ_W-1:0] irq_request = 4'h0;
  logic [`PMWC_IRQ_W-1:0] irq_enable = 4'h0;
  logic stack_full = 1'b0;
  logic req_stop = 1'b0;
  logic req_clr = 1'b0;
  logic stop_instr, watchdog_clear_instruction, sys_clk_en, fast_clk_run, slow_clk_run;
  logic slow_mode_active, cpu_halt, hold_state, hs_osc_stable_flag, power_down_flag;
  logic watchdog_timeout_flag, wdt_counter_clear, wdt_count_run, wake_resume;
  logic wake_irq_service, wake_pc_sp_reset;
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int n;
  int divs[8] = '{1, 2, 4, 8, 16, 64, 64, SLOW};

  pmwc_top #(.SLOW_DIV(SLOW)) dut (.*);
  pmwc_core_model core (.*);

  // Clock and hang limit
  initial forever #2 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end

  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && checks_done > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // Stop with the given idle enables, then check clocks and flags
  task automatic enter(input logic h, input logic l);
    @(posedge clk);
    hs_osc_idle_enable <= h;
    ls_osc_idle_enable <= l;
    req_stop <= 1'b1;
    @(posedge clk);
    req_stop <= 1'b0;
    @(posedge clk iff cpu_halt);
    repeat (3) @(posedge clk);
    #1;
    chk("fast_clk_run", 8'(fast_clk_run), 8'(h));
    chk("slow_clk_run", 8'(slow_clk_run), 8'(l));
    chk("power_down_flag", 8'(power_down_flag), 8'h1);
    chk("watchdog_timeout_flag", 8'(watchdog_timeout_flag), 8'h0);
    chk("hold_state", 8'(hold_state), 8'h1);
  endtask

  // Wait for a wake pulse; kind is {pc_sp_reset, irq_service, resume}
  task automatic wake(input logic [2:0] exp);
    logic [2:0] seen = 3'h0;
    while (seen == 3'h0) begin
      @(posedge clk);
      #1;
      seen = {wake_pc_sp_reset, wake_irq_service, wake_resume};
    end
    chk("wake_kind", {5'h0, seen}, {5'h0, exp});
  endtask

  initial begin
    repeat (11) @(posedge clk);
    #1;
    chk("reset fast_clk_run", 8'(fast_clk_run), 8'h1);
    chk("reset power_down_flag", 8'(power_down_flag), 8'h0);
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk iff hs_osc_stable_flag);
    // Every select code: tick rate of the system clock
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      clock_select_field <= 3'(i);
      repeat (128) @(posedge clk);
      n = 0;
      repeat (128) begin
        @(posedge clk);
        #1;
        n = n + int'(sys_clk_en);
      end
      chk("sys_clk_ticks", 8'(n), 8'(128 / divs[i]));
      chk("slow_mode_active", 8'(slow_mode_active), 8'(i == 7));
      chk("hs_osc_stable_flag", 8'(hs_osc_stable_flag), 8'(i != 7));
    end
    @(posedge clk);
    clock_select_field <= `PMWC_CKS_DIV1;
    repeat (20) @(posedge clk);
    #1;
    chk("slow_mode_active back", 8'(slow_mode_active), 8'h0);
    // Slow switch waits for a stable slow oscillator
    @(posedge clk);
    ls_osc_ready <= 1'b0;
    repeat (8) @(posedge clk);
    clock_select_field <= `PMWC_CKS_SLOW;
    repeat (20) @(posedge clk);
    #1;
    chk("slow_mode_active unstable", 8'(slow_mode_active), 8'h0);
    @(posedge clk);
    ls_osc_ready <= 1'b1;
    repeat (20) @(posedge clk);
    #1;
    chk("slow_mode_active stable", 8'(slow_mode_active), 8'h1);
    @(posedge clk);
    clock_select_field <= `PMWC_CKS_DIV1;
    repeat (20) @(posedge clk);
    #1;
    chk("hs_osc_stable_flag back", 8'(hs_osc_stable_flag), 8'h1);
    // Sleep, pin wake: a disabled pin falls first
    @(posedge clk);
    port_wake_enable <= 8'h01;
    enter(1'b0, 1'b0);
    @(posedge clk);
    port_pins <= 8'hfd;
    repeat (12) @(posedge clk);
    #1;
    chk("halt on disabled pin", 8'(cpu_halt), 8'h1);
    @(posedge clk);
    port_pins <= 8'hfc;
    wake(3'h1);
    @(posedge clk);
    port_pins <= 8'hff;
    irq_request <= 4'h1;
    // Flag set before entry cannot wake; a new enabled one is serviced
    enter(1'b0, 1'b1);
    repeat (12) @(posedge clk);
    #1;
    chk("halt on old irq", 8'(cpu_halt), 8'h1);
    @(posedge clk);
    irq_request <= 4'h3;
    irq_enable <= 4'h2;
    wake(3'h2);
    @(posedge clk);
    irq_request <= 4'h0;
    irq_enable <= 4'h4;
    stack_full <= 1'b1;
    enter(1'b1, 1'b1);
    @(posedge clk);
    irq_request <= 4'h4;
    wake(3'h1);
    @(posedge clk);
    irq_request <= 4'h0;
    irq_enable <= 4'h0;
    stack_full <= 1'b0;
    enter(1'b1, 1'b1);
    @(posedge clk);
    irq_request <= 4'h8;
    wake(3'h1);
    @(posedge clk);
    irq_request <= 4'h0;
    // Watchdog overflow wake, then the clear instruction
    enter(1'b1, 1'b0);
    @(posedge clk);
    wdt_overflow <= 1'b1;
    @(posedge clk);
    wdt_overflow <= 1'b0;
    #1;
    chk("wake_kind wdt", {5'h0, wake_pc_sp_reset, wake_irq_service, wake_resume}, 8'h04);
    chk("timeout flag", 8'(watchdog_timeout_flag), 8'h1);
    chk("power down kept", 8'(power_down_flag), 8'h1);
    @(posedge clk);
    req_clr <= 1'b1;
    @(posedge clk);
    req_clr <= 1'b0;
    wdt_enable <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("power down cleared", 8'(power_down_flag), 8'h0);
    chk("wdt_count_run", 8'(wdt_count_run), 8'h0);
    stop_test();
  end
endmodule
